// file: core/status_reporting.sv
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module status_reporting (
    input wire logic core_clk, // 200 MHz clock
    input wire logic sys_rst, // async reset, active high
    input wire status_pkg::bus_req_s bus_req, // register access
    input wire logic [15:0] questionable_summary_bit_cond_pin, // live questionable conditions
    input wire logic [7:0] std_event_set, // standard event pulses
    input wire logic ops_pending, // operations still running
    input wire logic msg_terminator, // program message terminator seen
    input wire logic out_queue_nonempty, // output queue holds a message
    input wire logic err_queue_nonempty, // error queue holds entries
    output logic [15:0] rdata, // read data, cycle after strobe
    output logic command_hold, // stall following commands
    output logic srq_out, // service request to controller
    output logic err_queue_clear, // pulse: empty error queue
    output logic out_queue_clear // pulse: empty output queue
);
    import status_pkg::*;

    logic [15:0] cond_s1_reg, cond_reg, cond_prev_reg;
    logic [15:0] questionable_summary_bit_event_reg, questionable_summary_bit_enable_reg; // 16 wide
    logic [15:0] questionable_summary_bit_fall_reg, questionable_summary_bit_rise_reg;
    logic [7:0] std_event_reg, std_enable_reg, srq_enable_reg;
    logic rqs_reg, after_term_reg, opc_answer_ready_reg, mss_prev_reg;
    logic pend_s1_reg, pend_reg;
    logic [15:0] questionable_summary_bit_event_next;
    logic [7:0] std_event_next, status_byte;
    logic [15:0] questionable_summary_bit_hit;
    logic questionable_summary_bit_sum, esb_sum, master_summary_bit, opc_done;
    logic wr_cmd, preset, clear_status, cmd_opc, cmd_opcq, poll;
    logic rd_questionable_summary_bit_event, rd_std_event;
    opc_state_e opc_state_reg, opc_state_next;

    // conditions and pending flag come from outside: two flops first
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cond_s1_reg <= 16'h0000;
            cond_reg <= 16'h0000;
            cond_prev_reg <= 16'h0000;
            pend_s1_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else begin
            cond_s1_reg <= questionable_summary_bit_cond_pin;
            cond_reg <= cond_s1_reg; // live, never latched
            cond_prev_reg <= cond_reg;
            pend_s1_reg <= ops_pending;
            pend_reg <= pend_s1_reg;
        end
    end

    // command decode; commands held off while a query is outstanding
    assign wr_cmd = bus_req.wr && bus_req.addr == command_off
        && !command_hold;
    assign preset = wr_cmd && bus_req.wdata == cmd_preset;
    assign clear_status = wr_cmd && bus_req.wdata == cmd_clear_status;
    assign cmd_opc = wr_cmd && bus_req.wdata == cmd_op_complete;
    assign cmd_opcq = wr_cmd && bus_req.wdata == cmd_op_complete_query;
    assign poll = wr_cmd && bus_req.wdata == cmd_serial_poll;
    assign rd_questionable_summary_bit_event = bus_req.rd && bus_req.addr == questionable_summary_bit_event_off;
    assign rd_std_event = bus_req.rd && bus_req.addr == std_event_off;

    // transition filters feed the event latch
    assign questionable_summary_bit_hit = (questionable_summary_bit_rise_reg & cond_reg & ~cond_prev_reg)
        | (questionable_summary_bit_fall_reg & ~cond_reg & cond_prev_reg);

    // set wins over a same-cycle clear
    always_comb begin
        questionable_summary_bit_event_next = questionable_summary_bit_event_reg;
        if (rd_questionable_summary_bit_event || clear_status) begin
            questionable_summary_bit_event_next = 16'h0000;
        end
        questionable_summary_bit_event_next = questionable_summary_bit_event_next | questionable_summary_bit_hit;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            questionable_summary_bit_event_reg <= 16'h0000;
        end else begin
            questionable_summary_bit_event_reg <= questionable_summary_bit_event_next;
        end
    end

    // opc bit set once current operation has finished
    assign opc_done = opc_state_reg == opc_wait_bit && !pend_reg;

    always_comb begin
        std_event_next = std_event_reg;
        if (rd_std_event || clear_status) begin
            std_event_next = 8'h00;
        end
        std_event_next = std_event_next | std_event_set;
        if (opc_done) begin
            std_event_next[opc_bit_pos] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            std_event_reg <= 8'h00;
        end else begin
            std_event_reg <= std_event_next; // latches
        end
    end

    // writable masks and filters; preset overrides a same-cycle write
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            questionable_summary_bit_enable_reg <= questionable_summary_bit_enable_rst;
            questionable_summary_bit_fall_reg <= questionable_summary_bit_fall_rst;
            questionable_summary_bit_rise_reg <= questionable_summary_bit_rise_rst;
            std_enable_reg <= std_enable_rst;
            srq_enable_reg <= srq_enable_rst;
        end else if (preset) begin
            questionable_summary_bit_enable_reg <= 16'h0000;
            questionable_summary_bit_rise_reg <= 16'hffff;
            questionable_summary_bit_fall_reg <= 16'h0000;
        end else if (bus_req.wr && !command_hold) begin
            if (bus_req.addr == questionable_summary_bit_enable_off) begin
                questionable_summary_bit_enable_reg <= bus_req.wdata;
            end else if (bus_req.addr == questionable_summary_bit_fall_off) begin
                questionable_summary_bit_fall_reg <= bus_req.wdata;
            end else if (bus_req.addr == questionable_summary_bit_rise_off) begin
                questionable_summary_bit_rise_reg <= bus_req.wdata;
            end else if (bus_req.addr == std_enable_off) begin
                std_enable_reg <= bus_req.wdata[7:0];
            end else if (bus_req.addr == srq_enable_off) begin
                srq_enable_reg <= bus_req.wdata[7:0];
            end
        end
    end

    // summaries
    assign questionable_summary_bit_sum = |(questionable_summary_bit_event_reg & questionable_summary_bit_enable_reg);
    assign esb_sum = |(std_event_reg & std_enable_reg);

    // status byte; queue bits from live queue state
    always_comb begin
        status_byte = 8'h00;
        status_byte[sb_err_pos] = err_queue_nonempty;
        status_byte[sb_questionable_summary_bit_pos] = questionable_summary_bit_sum;
        status_byte[sb_mav_pos] = out_queue_nonempty;
        status_byte[sb_esb_pos] = esb_sum;
        status_byte[sb_rqs_pos] = master_summary_bit;
    end

    // bit 6 itself is never part of the summing
    assign master_summary_bit = |(status_byte_raw() & srq_enable_reg);

    function automatic logic [7:0] status_byte_raw();
        logic [7:0] b;
        b = 8'h00;
        b[sb_err_pos] = err_queue_nonempty;
        b[sb_questionable_summary_bit_pos] = questionable_summary_bit_sum;
        b[sb_mav_pos] = out_queue_nonempty;
        b[sb_esb_pos] = esb_sum;
        return b;
    endfunction : status_byte_raw

    // request bit: set only on a fresh summary rise, so a poll
    // cannot be followed by a re-request while the summary stays up
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mss_prev_reg <= 1'b0;
            rqs_reg <= 1'b0;
            srq_out <= 1'b0;
        end else begin
            mss_prev_reg <= master_summary_bit;
            if (master_summary_bit && !mss_prev_reg) begin
                rqs_reg <= 1'b1;
                srq_out <= 1'b1;
            end else if (poll || clear_status || !master_summary_bit) begin
                rqs_reg <= 1'b0;
                srq_out <= 1'b0;
            end
        end
    end

    // remembers whether the last thing seen was a terminator
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            after_term_reg <= 1'b0;
        end else if (msg_terminator) begin
            after_term_reg <= 1'b1;
        end else if (bus_req.wr) begin
            after_term_reg <= 1'b0;
        end
    end

    // queue clear pulses
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            err_queue_clear <= 1'b0;
            out_queue_clear <= 1'b0;
        end else begin
            err_queue_clear <= clear_status;
            out_queue_clear <= clear_status && after_term_reg;
        end
    end

    // operation-complete sequencing
    always_comb begin
        opc_state_next = opc_state_reg;
        case (opc_state_reg)
            opc_idle: begin
                if (cmd_opcq) begin
                    opc_state_next = opc_wait_query;
                end else if (cmd_opc) begin
                    opc_state_next = opc_wait_bit;
                end
            end
            opc_wait_bit: begin
                if (!pend_reg) begin
                    opc_state_next = opc_idle;
                end else if (cmd_opcq) begin
                    opc_state_next = opc_wait_query;
                end
            end
            opc_wait_query: begin
                if (!pend_reg) begin
                    opc_state_next = opc_idle;
                end
            end
            default: begin
                opc_state_next = opc_idle;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            opc_state_reg <= opc_idle;
            command_hold <= 1'b0;
            opc_answer_ready_reg <= 1'b0;
        end else begin
            opc_state_reg <= opc_state_next;
            command_hold <= opc_state_next == opc_wait_query;
            if (opc_state_reg == opc_wait_query && !pend_reg) begin
                opc_answer_ready_reg <= 1'b1;
            end else if (bus_req.rd && bus_req.addr == opc_answer_off) begin
                opc_answer_ready_reg <= 1'b0;
            end
        end
    end

    // read mux; data stands the cycle after the strobe only
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= 16'h0000;
        end else if (!bus_req.rd) begin
            rdata <= 16'h0000;
        end else if (bus_req.addr == questionable_summary_bit_event_off) begin
            rdata <= questionable_summary_bit_event_reg;
        end else if (bus_req.addr == questionable_summary_bit_cond_off) begin
            rdata <= cond_reg;
        end else if (bus_req.addr == questionable_summary_bit_enable_off) begin
            rdata <= questionable_summary_bit_enable_reg;
        end else if (bus_req.addr == questionable_summary_bit_fall_off) begin
            rdata <= questionable_summary_bit_fall_reg;
        end else if (bus_req.addr == questionable_summary_bit_rise_off) begin
            rdata <= questionable_summary_bit_rise_reg;
        end else if (bus_req.addr == std_event_off) begin
            rdata <= {8'h00, std_event_reg};
        end else if (bus_req.addr == std_enable_off) begin
            rdata <= {8'h00, std_enable_reg};
        end else if (bus_req.addr == status_byte_off) begin
            rdata <= {8'h00, status_byte};
        end else if (bus_req.addr == srq_enable_off) begin
            rdata <= {8'h00, srq_enable_reg};
        end else if (bus_req.addr == opc_answer_off) begin
            rdata <= opc_answer_ready_reg ? opc_answer_val : 16'h0000;
        end else begin
            rdata <= 16'h0000; // unmapped reads zero
        end
    end
endmodule : status_reporting

// file: shared/status_pkg.sv
package status_pkg;
    localparam int addr_w = 4;
    localparam int data_w = 16;
    // register offsets
    localparam logic [3:0] questionable_summary_bit_event_off = 4'h0;
    localparam logic [3:0] questionable_summary_bit_cond_off = 4'h1;
    localparam logic [3:0] questionable_summary_bit_enable_off = 4'h2;
    localparam logic [3:0] questionable_summary_bit_fall_off = 4'h3;
    localparam logic [3:0] questionable_summary_bit_rise_off = 4'h4;
    localparam logic [3:0] std_event_off = 4'h5;
    localparam logic [3:0] std_enable_off = 4'h6;
    localparam logic [3:0] status_byte_off = 4'h7;
    localparam logic [3:0] srq_enable_off = 4'h8;
    localparam logic [3:0] command_off = 4'h9;
    localparam logic [3:0] opc_answer_off = 4'ha;
    // command codes written to command_off
    localparam logic [15:0] cmd_preset = 16'h0001;
    localparam logic [15:0] cmd_clear_status = 16'h0002;
    localparam logic [15:0] cmd_op_complete = 16'h0003;
    localparam logic [15:0] cmd_op_complete_query = 16'h0004;
    localparam logic [15:0] cmd_serial_poll = 16'h0005;
    // status byte bit positions, then the opc bit in the standard event register
    localparam int sb_err_pos = 2;
    localparam int sb_questionable_summary_bit_pos = 3;
    localparam int sb_mav_pos = 4;
    localparam int sb_esb_pos = 5;
    localparam int sb_rqs_pos = 6;
    localparam int opc_bit_pos = 0;
    // reset values, then the opc query answer value
    localparam logic [15:0] questionable_summary_bit_enable_rst = 16'h0000;
    localparam logic [15:0] questionable_summary_bit_fall_rst = 16'h0000;
    localparam logic [15:0] questionable_summary_bit_rise_rst = 16'hffff;
    localparam logic [7:0] std_enable_rst = 8'h00;
    localparam logic [7:0] srq_enable_rst = 8'h00;
    localparam logic [15:0] opc_answer_val = 16'h0001;

    typedef struct packed {
        logic [addr_w-1:0] addr;
        logic [data_w-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    typedef enum logic [1:0] {
        opc_idle = 2'b00,
        opc_wait_bit = 2'b01,
        opc_wait_query = 2'b10
    } opc_state_e;
endpackage : status_pkg

// file: verification/queue_model.sv
`timescale 1ns/1ps
module queue_model (
    input wire logic core_clk, // clock
    input wire logic sys_rst, // async reset
    input wire logic err_queue_clear, // empty the error queue
    input wire logic out_queue_clear, // empty the output queue
    output logic err_queue_nonempty, // errors waiting
    output logic out_queue_nonempty // response waiting
);
    // queues start loaded so both status byte bits are seen to drop
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            err_queue_nonempty <= 1'b1;
        end else if (err_queue_clear) begin
            err_queue_nonempty <= 1'b0;
        end
    end
    // output queue empties only on the terminator case
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_queue_nonempty <= 1'b1;
        end else if (out_queue_clear) begin
            out_queue_nonempty <= 1'b0;
        end
    end
endmodule : queue_model

// file: verification/status_reporting_props.sv
`timescale 1ns/1ps
module status_props (
    input wire logic core_clk, // clock
    input wire logic sys_rst, // async reset
    input wire status_pkg::bus_req_s bus_req, // register access
    input wire logic [15:0] questionable_summary_bit_cond_pin, // live conditions
    input wire logic ops_pending, // operations running
    input wire logic [15:0] rdata, // read data
    input wire logic command_hold, // stall
    input wire logic srq_out, // service request
    input wire logic err_queue_clear, // error queue pulse
    input wire logic out_queue_clear // output queue pulse
);
    import status_pkg::*;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    logic [2:0] zero_cnt;
    // age of an all-zero service enable; 0 means enable is nonzero
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            zero_cnt <= 3'h7;
        end else if (bus_req.wr && bus_req.addr == srq_enable_off
                     && !command_hold) begin
            zero_cnt <= (bus_req.wdata[7:0] == 8'h00) ? 3'h1 : 3'h0;
        end else if (zero_cnt != 3'h0 && zero_cnt != 3'h7) begin
            zero_cnt <= zero_cnt + 3'h1;
        end
    end
    sequence cmd_s(logic [15:0] c);
        bus_req.wr && bus_req.addr == command_off && bus_req.wdata == c
            && !command_hold;
    endsequence
    idle_read_a: assert property (!bus_req.rd |=> rdata == 16'h0000)
        else $error("read data not zero outside a read");
    narrow_upper_a: assert property (bus_req.rd && bus_req.addr >= 4'h5
        && bus_req.addr <= 4'h8 |=> rdata[15:8] == 8'h00)
        else $error("upper byte of narrow register not zero");
    cond_live_a: assert property (bus_req.rd && bus_req.addr == questionable_summary_bit_cond_off
        && $stable(questionable_summary_bit_cond_pin) && questionable_summary_bit_cond_pin == $past(questionable_summary_bit_cond_pin, 3)
        |=> rdata == $past(questionable_summary_bit_cond_pin))
        else $error("condition read differs from live input");
    err_clear_a: assert property (cmd_s(cmd_clear_status) |=> err_queue_clear)
        else $error("clear status did not empty error queue");
    out_clear_a: assert property (out_queue_clear |-> $past(bus_req.wr)
        && $past(bus_req.wdata) == cmd_clear_status)
        else $error("output queue cleared without clear status");
    hold_rise_a: assert property (cmd_s(cmd_op_complete_query)
        |=> command_hold)
        else $error("completion query did not hold commands");
    hold_fall_a: assert property ($fell(command_hold) |->
        !$past(ops_pending) && !$past(ops_pending, 2))
        else $error("hold released while operations pending");
    poll_clear_a: assert property (cmd_s(cmd_serial_poll)
        |-> ##[1:3] !srq_out)
        else $error("serial poll left request raised");
    zero_enable_a: assert property (zero_cnt >= 3'h4 |-> !srq_out)
        else $error("request raised with zero service enable");
    preset_seen_c: cover property (cmd_s(cmd_preset));
endmodule : status_props
bind status_reporting status_props status_props_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .bus_req(bus_req), .questionable_summary_bit_cond_pin(questionable_summary_bit_cond_pin),
    .ops_pending(ops_pending), .rdata(rdata), .command_hold(command_hold),
    .srq_out(srq_out), .err_queue_clear(err_queue_clear),
    .out_queue_clear(out_queue_clear));

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    import status_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    bus_req_s bus_req = '0;
    logic [15:0] questionable_summary_bit_cond_pin = 16'h0000;
    logic [7:0] std_event_set = 8'h00;
    logic ops_pending = 1'b0;
    logic msg_terminator = 1'b0;
    logic out_queue_nonempty;
    logic err_queue_nonempty;
    logic [15:0] rdata;
    logic command_hold;
    logic srq_out;
    logic err_queue_clear;
    logic out_queue_clear;
    int n_fail = 0;
    int comparisons = 0;
    // 200 MHz clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    status_reporting status_reporting_i (.core_clk(core_clk),
        .sys_rst(sys_rst), .bus_req(bus_req), .questionable_summary_bit_cond_pin(questionable_summary_bit_cond_pin),
        .std_event_set(std_event_set), .ops_pending(ops_pending),
        .msg_terminator(msg_terminator),
        .out_queue_nonempty(out_queue_nonempty),
        .err_queue_nonempty(err_queue_nonempty), .rdata(rdata),
        .command_hold(command_hold), .srq_out(srq_out),
        .err_queue_clear(err_queue_clear), .out_queue_clear(out_queue_clear));
    queue_model queue_model_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .err_queue_clear(err_queue_clear), .out_queue_clear(out_queue_clear),
        .err_queue_nonempty(err_queue_nonempty),
        .out_queue_nonempty(out_queue_nonempty));
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // single-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus_req.wr <= 1'b1;
        bus_req.addr <= a;
        bus_req.wdata <= d;
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask : wr
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
        @(posedge core_clk);
        bus_req.rd <= 1'b1;
        bus_req.addr <= a;
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask : rd
    // wait out the input synchroniser and event latch
    task automatic set_cond(input logic [15:0] v);
        @(posedge core_clk);
        questionable_summary_bit_cond_pin <= v;
        repeat (6) @(posedge core_clk);
    endtask : set_cond
    task automatic pulse_std(input logic [7:0] v);
        @(posedge core_clk);
        std_event_set <= v;
        @(posedge core_clk);
        std_event_set <= 8'h00;
        repeat (3) @(posedge core_clk);
    endtask : pulse_std
    task automatic set_pending(input logic v);
        @(posedge core_clk);
        ops_pending <= v;
        repeat (6) @(posedge core_clk);
    endtask : set_pending
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        $display("watchdog expired");
        stop_test();
    end
    // main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(questionable_summary_bit_rise_off, 16'hffff, "rise");
        rd(questionable_summary_bit_fall_off, 16'h0000, "fall");
        rd(questionable_summary_bit_enable_off, 16'h0000, "questionable_summary_bit_en");
        rd(srq_enable_off, 16'h0000, "srq_en");
        $display("test reset done");
        wr(questionable_summary_bit_fall_off, 16'h0002);
        wr(questionable_summary_bit_rise_off, 16'h0001);
        rd(questionable_summary_bit_fall_off, 16'h0002, "fall");
        set_cond(16'h0003);
        rd(questionable_summary_bit_cond_off, 16'h0003, "cond");
        rd(questionable_summary_bit_event_off, 16'h0001, "questionable_summary_bit_ev");
        rd(questionable_summary_bit_event_off, 16'h0000, "questionable_summary_bit_ev");
        set_cond(16'h0000);
        rd(questionable_summary_bit_cond_off, 16'h0000, "cond");
        rd(questionable_summary_bit_event_off, 16'h0002, "questionable_summary_bit_ev");
        $display("test filters done");
        wr(questionable_summary_bit_enable_off, 16'h0001);
        wr(srq_enable_off, 16'h0008);
        set_cond(16'h0001);
        rd(status_byte_off, 16'h005c, "stb");
        rd(status_byte_off, 16'h005c, "stb");
        chk("srq_out", 16'h0001, {15'h0, srq_out});
        wr(command_off, cmd_serial_poll);
        rd(status_byte_off, 16'h005c, "stb");
        chk("srq_out", 16'h0000, {15'h0, srq_out});
        wr(command_off, cmd_clear_status);
        rd(questionable_summary_bit_enable_off, 16'h0001, "questionable_summary_bit_en");
        rd(questionable_summary_bit_event_off, 16'h0000, "questionable_summary_bit_ev");
        rd(status_byte_off, 16'h0010, "stb");
        @(posedge core_clk);
        msg_terminator <= 1'b1;
        @(posedge core_clk);
        msg_terminator <= 1'b0;
        wr(command_off, cmd_clear_status);
        rd(status_byte_off, 16'h0000, "stb");
        $display("test summary done");
        wr(questionable_summary_bit_fall_off, 16'h00f0);
        wr(questionable_summary_bit_rise_off, 16'h0000);
        wr(command_off, cmd_preset);
        rd(questionable_summary_bit_enable_off, 16'h0000, "questionable_summary_bit_en");
        rd(questionable_summary_bit_rise_off, 16'hffff, "rise");
        rd(questionable_summary_bit_fall_off, 16'h0000, "fall");
        $display("test preset done");
        wr(std_enable_off, 16'h0020);
        wr(srq_enable_off, 16'h0020);
        pulse_std(8'h24);
        rd(status_byte_off, 16'h0060, "stb");
        rd(std_event_off, 16'h0024, "std_ev");
        rd(std_event_off, 16'h0000, "std_ev");
        wr(srq_enable_off, 16'h0000);
        wr(std_enable_off, 16'h0004);
        pulse_std(8'h04);
        rd(status_byte_off, 16'h0020, "stb");
        chk("srq_out", 16'h0000, {15'h0, srq_out});
        wr(command_off, cmd_clear_status);
        rd(std_event_off, 16'h0000, "std_ev");
        $display("test standard done");
        set_pending(1'b1);
        wr(command_off, cmd_op_complete);
        rd(std_event_off, 16'h0000, "std_ev");
        set_pending(1'b0);
        rd(std_event_off, 16'h0001, "std_ev");
        set_pending(1'b1);
        wr(command_off, cmd_op_complete_query);
        rd(opc_answer_off, 16'h0000, "opc_ans");
        chk("hold", 16'h0001, {15'h0, command_hold});
        wr(std_enable_off, 16'h00ff);
        set_pending(1'b0);
        chk("hold", 16'h0000, {15'h0, command_hold});
        rd(std_enable_off, 16'h0004, "std_en");
        rd(opc_answer_off, 16'h0001, "opc_ans");
        rd(opc_answer_off, 16'h0000, "opc_ans");
        $display("test completion done");
        stop_test();
    end
endmodule : testbench
